// *** rtl/isab_bus_if.sv ***
// Purpose: expansion bus cycle engine, limited and master modes
// Assumes: one request at a time, strobes active low
// Notes: bus clock taken as sys_clk for cycle counts
`timescale 1ns/1ps
`default_nettype none
module isab_bus_if #(
  parameter int DMA_CHANNELS = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // configuration
  input wire logic masterModeStrap,
  input wire logic [7:0] upperPinCfg,
  input wire logic clockChipMode,
  input wire logic [2:0] romRange,
  // request port
  input wire logic reqValid,
  input wire isab_pkg::isab_cycle_type reqType,
  input wire logic [23:0] reqAddr,
  input wire logic [15:0] reqWdata,
  input wire logic reqWide,
  output logic reqReady,
  output logic [15:0] rspRdata,
  output logic rspValid,
  input wire logic slaveBusy,
  // dma port
  input wire logic dmaStart,
  input wire logic [2:0] dmaChannel,
  input wire logic dmaWide,
  input wire logic dmaLast,
  input wire logic pciAddrBit0,
  // bus pins
  output logic [15:0] sharedAddrDataOut,
  output logic sharedAddrDataOe,
  input wire logic [15:0] sharedAddrDataIn,
  output logic [15:0] panelAddr,
  output logic [3:0] upperAddr,
  output logic [3:0] upperAddrOe,
  output logic [3:0] generalIoOut,
  input wire logic [3:0] generalIoIn,
  output logic [3:0] generalIoSeen,
  output logic addr_latch_out,
  output logic addr_xcvr_enable_n,
  input wire logic busMasterPin_n,
  output logic pin_low_mem_write_n_clock_chip_select_n_n,
  output logic pin_low_mem_read_n_clock_chip_addr_latch,
  output logic byteHighEnableOut_n,
  output logic byteHighEnableOe,
  input wire logic byteHighEnableIn_n,
  output logic buffered_addr_latch,
  input wire logic channelReadyIn,
  output logic channelReadyOe,
  input wire logic no_wait_request_n,
  input wire logic io_wide_select_n,
  input wire logic mem_wide_select_n,
  output logic mem_read_n,
  output logic mem_write_n,
  output logic io_read_n,
  output logic io_write_n,
  output logic dma_addr_enable,
  input wire logic [DMA_CHANNELS-1:0] dma_request,
  output logic [DMA_CHANNELS-1:0] dma_acknowledge_n,
  output logic dma_final_count,
  output logic kbd_rom_select_n,
  output logic extMasterOwns
);
  import isab_pkg::*;

  if (DMA_CHANNELS != 8) begin : g_bad_channels
    $error("isab_bus_if: eight dma channels only");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LATCH, ST_CMD, ST_WAIT, ST_DONE} isab_state_type;
  isab_state_type state;

  logic masterMode;
  logic modeCaught;
  logic readySync;
  logic zwsSync_n;
  logic ioWideSync_n;
  logic memWideSync_n;
  logic masterSync_n;
  logic bheSync_n;
  logic [3:0] gpioSync;
  logic [DMA_CHANNELS-1:0] drqSync;
  isab_cycle_type cycType;
  logic [23:0] cycAddr;
  logic [15:0] cycWdata;
  logic cycWide;
  logic inDma;
  logic dmaFinal;
  logic [2:0] dmaChan;
  logic [3:0] count;
  logic zwsSeen;
  logic rtcHit;
  logic kbdRomHit;
  logic lowMeg;
  logic isMem;
  logic isRead;
  logic cmdActive;
  logic pathWide;
  logic lowReadStrobe_n;
  logic clockChipLatch;

  isab_sync #(.RESET_VALUE(1'b1)) u_sync_rdy (.sys_clk(sys_clk), .arst_n(arst_n), .din(channelReadyIn), .dout(readySync));
  isab_sync #(.RESET_VALUE(1'b1)) u_sync_zws (.sys_clk(sys_clk), .arst_n(arst_n), .din(no_wait_request_n), .dout(zwsSync_n));
  isab_sync #(.RESET_VALUE(1'b1)) u_sync_ios (.sys_clk(sys_clk), .arst_n(arst_n), .din(io_wide_select_n), .dout(ioWideSync_n));
  isab_sync #(.RESET_VALUE(1'b1)) u_sync_mcs (.sys_clk(sys_clk), .arst_n(arst_n), .din(mem_wide_select_n), .dout(memWideSync_n));
  isab_sync #(.RESET_VALUE(1'b1)) u_sync_mst (.sys_clk(sys_clk), .arst_n(arst_n), .din(busMasterPin_n), .dout(masterSync_n));
  isab_sync #(.RESET_VALUE(1'b1)) u_sync_bhe (.sys_clk(sys_clk), .arst_n(arst_n), .din(byteHighEnableIn_n), .dout(bheSync_n));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gpio
      isab_sync u_sync_gpio (.sys_clk(sys_clk), .arst_n(arst_n), .din(generalIoIn[gi]), .dout(gpioSync[gi]));
    end
    for (gi = 0; gi < DMA_CHANNELS; gi++) begin : g_drq
      isab_sync u_sync_drq (.sys_clk(sys_clk), .arst_n(arst_n), .din(dma_request[gi]), .dout(drqSync[gi]));
    end
  endgenerate

  isab_decode u_decode (
    .cycType(cycType),
    .cycAddr(cycAddr),
    .romRange(romRange),
    .rtcHit(rtcHit),
    .kbdRomHit(kbdRomHit),
    .lowMeg(lowMeg)
  );

  // strap caught once after release, never under reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      masterMode <= 1'b0;
      modeCaught <= 1'b0;
    end else if (!modeCaught) begin
      masterMode <= masterModeStrap;
      modeCaught <= 1'b1;
    end
  end

  assign extMasterOwns = masterMode && !masterSync_n;
  assign isMem = (cycType == CYC_MEM_RD) || (cycType == CYC_MEM_WR);
  assign isRead = (cycType == CYC_MEM_RD) || (cycType == CYC_IO_RD);
  assign cmdActive = (state == ST_CMD) || (state == ST_WAIT);
  assign pathWide = cycWide && (isMem ? !memWideSync_n : !ioWideSync_n);
  assign reqReady = (state == ST_IDLE) && modeCaught && !extMasterOwns;

  // cycle sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      count <= 4'h0;
      zwsSeen <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          zwsSeen <= 1'b0;
          if ((reqValid && reqReady) || (dmaStart && !extMasterOwns && modeCaught && drqSync[dmaChannel])) begin
            state <= ST_ADDR;
            count <= ADDR_PHASE_CYCLES;
          end
        end
        ST_ADDR: state <= ST_LATCH;
        ST_LATCH: begin
          state <= ST_CMD;
          count <= pathWide ? CMD_CYCLES_16 : CMD_CYCLES_8;
        end
        ST_CMD: begin
          if (isMem && !zwsSync_n && !zwsSeen) begin
            zwsSeen <= 1'b1;
            count <= (pathWide ? ZWS_CYCLES_16 : ZWS_CYCLES_8) - 4'h1;
          end else if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: if (readySync) state <= ST_DONE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // captured cycle and dma context
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cycType <= CYC_MEM_RD;
      cycAddr <= 24'h000000;
      cycWdata <= 16'h0000;
      cycWide <= 1'b0;
      inDma <= 1'b0;
      dmaFinal <= 1'b0;
      dmaChan <= 3'h0;
    end else if (state == ST_IDLE) begin
      if (reqValid && reqReady) begin
        cycType <= reqType;
        cycAddr <= reqAddr;
        cycWdata <= reqWdata;
        cycWide <= reqWide;
        inDma <= 1'b0;
      end else if (dmaStart && modeCaught && !extMasterOwns && drqSync[dmaChannel]) begin
        cycType <= reqType;
        cycAddr <= reqAddr;
        cycWdata <= reqWdata;
        cycWide <= dmaWide;
        inDma <= 1'b1;
        dmaFinal <= dmaLast;
        dmaChan <= dmaChannel;
      end
    end else if (state == ST_DONE) begin
      inDma <= 1'b0;
    end
  end

  // read data capture, low byte only on narrow path
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspRdata <= 16'h0000;
      rspValid <= 1'b0;
    end else begin
      rspValid <= (state == ST_DONE);
      if (state == ST_WAIT && readySync && isRead) begin
        rspRdata <= pathWide ? sharedAddrDataIn : {8'h00, sharedAddrDataIn[7:0]};
      end
    end
  end

  // pin drivers, registered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sharedAddrDataOut <= 16'h0000;
      sharedAddrDataOe <= 1'b0;
      panelAddr <= 16'h0000;
      addr_latch_out <= 1'b0;
      buffered_addr_latch <= 1'b0;
      mem_read_n <= 1'b1;
      mem_write_n <= 1'b1;
      io_read_n <= 1'b1;
      io_write_n <= 1'b1;
      pin_low_mem_write_n_clock_chip_select_n_n <= 1'b1;
      lowReadStrobe_n <= 1'b1;
      clockChipLatch <= 1'b0;
      kbd_rom_select_n <= 1'b1;
      dma_addr_enable <= 1'b0;
      dma_acknowledge_n <= '1;
      dma_final_count <= 1'b0;
      byteHighEnableOut_n <= 1'b1;
      channelReadyOe <= 1'b0;
    end else begin
      if (masterMode) begin
        panelAddr <= cycAddr[15:0];
        sharedAddrDataOut <= cycWdata;
        sharedAddrDataOe <= cmdActive && !isRead && !extMasterOwns;
      end else begin
        sharedAddrDataOut <= (state == ST_ADDR || state == ST_LATCH) ? cycAddr[15:0] : cycWdata;
        sharedAddrDataOe <= (state == ST_ADDR || state == ST_LATCH) || (cmdActive && !isRead);
      end
      addr_latch_out <= masterMode ? extMasterOwns : (state == ST_LATCH);
      buffered_addr_latch <= (state == ST_LATCH) || (inDma && state != ST_IDLE && state != ST_DONE);
      mem_read_n <= !(cmdActive && cycType == CYC_MEM_RD);
      mem_write_n <= !(cmdActive && cycType == CYC_MEM_WR);
      io_read_n <= !(cmdActive && cycType == CYC_IO_RD);
      io_write_n <= !(cmdActive && cycType == CYC_IO_WR);
      if (clockChipMode) begin
        pin_low_mem_write_n_clock_chip_select_n_n <= !(cmdActive && rtcHit);
      end else begin
        pin_low_mem_write_n_clock_chip_select_n_n <= !(cmdActive && cycType == CYC_MEM_WR && lowMeg);
      end
      clockChipLatch <= (state == ST_LATCH) && rtcHit;
      lowReadStrobe_n <= !(cmdActive && cycType == CYC_MEM_RD && lowMeg);
      kbd_rom_select_n <= !(cmdActive && kbdRomHit);
      dma_addr_enable <= inDma && state != ST_IDLE && state != ST_DONE;
      for (int i = 0; i < DMA_CHANNELS; i++) begin
        dma_acknowledge_n[i] <= !(inDma && state != ST_IDLE && dmaChan == 3'(i));
      end
      dma_final_count <= inDma && dmaFinal && state == ST_WAIT && readySync;
      byteHighEnableOut_n <= inDma ? (cycWide ? 1'b0 : !pciAddrBit0) : !(cycWide || cycAddr[0]);
      channelReadyOe <= extMasterOwns && slaveBusy;
    end
  end

  // byte-high is an input under external master
  assign byteHighEnableOe = !extMasterOwns && modeCaught;
  assign addr_xcvr_enable_n = !masterMode;
  assign generalIoSeen = gpioSync;

  // upper address pins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      upperAddr <= 4'h0;
      upperAddrOe <= 4'h0;
      generalIoOut <= 4'h0;
    end else begin
      upperAddr <= cycAddr[23:20];
      generalIoOut <= upperPinCfg[7:4];
      if (masterMode) begin
        upperAddrOe <= extMasterOwns ? 4'h0 : 4'hF;
      end else begin
        upperAddrOe <= (upperPinCfg[CFG_UPPER_SEL_A] || upperPinCfg[CFG_UPPER_SEL_B]) ? 4'hF : upperPinCfg[3:0];
      end
    end
  end

  // muxed after the flops so the pin idles at the level of its function, also straight after reset
  assign pin_low_mem_read_n_clock_chip_addr_latch = clockChipMode ? clockChipLatch : lowReadStrobe_n;
  // shares the latch pin in master mode; kept as an unused internal copy of bhe sample
  logic unusedBhe;
  assign unusedBhe = bheSync_n;
endmodule : isab_bus_if
`default_nettype wire

// *** rtl/isab_decode.sv ***
// Purpose: chip select and strobe qualification decode
// Assumes: address held stable for the cycle
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module isab_decode (
  // cycle
  input wire isab_pkg::isab_cycle_type cycType,
  input wire logic [23:0] cycAddr,
  input wire logic [2:0] romRange,
  // selects
  output logic rtcHit,
  output logic kbdRomHit,
  output logic lowMeg
);
  import isab_pkg::*;
  logic isIo;
  logic romHit;
  always_comb begin
    isIo = (cycType == CYC_IO_RD) || (cycType == CYC_IO_WR);
    lowMeg = (cycAddr < LOW_MEG_LIMIT);
    rtcHit = isIo && (cycAddr[15:0] == RTC_PORT);
    // bits 0 and 1 each open one 64k window below 1 MB top (f0000, e0000), bit 2 the 1 MB window at 16M top
    romHit = (romRange[0] && cycAddr[23:16] == 8'h0F) ||
             (romRange[1] && cycAddr[23:16] == 8'h0E) ||
             (romRange[2] && cycAddr[23:20] == 4'hF);
    kbdRomHit = (isIo && (cycAddr[15:0] == KBD_PORT_A || cycAddr[15:0] == KBD_PORT_B ||
                 cycAddr[15:0] == KBD_PORT_C || cycAddr[15:0] == KBD_PORT_D)) ||
                (!isIo && romHit);
  end
endmodule : isab_decode
`default_nettype wire

// *** rtl/isab_pkg.sv ***
// Purpose: shared constants for the expansion bus interface
// Assumes: 125 MHz system clock
// Notes: cycle lengths counted in system clocks standing in for bus clocks
package isab_pkg;
  localparam logic [15:0] RTC_PORT = 16'h0071;
  localparam logic [15:0] KBD_PORT_A = 16'h0060;
  localparam logic [15:0] KBD_PORT_B = 16'h0062;
  localparam logic [15:0] KBD_PORT_C = 16'h0064;
  localparam logic [15:0] KBD_PORT_D = 16'h0066;
  localparam logic [23:0] LOW_MEG_LIMIT = 24'h100000;
  localparam int CFG_UPPER_SEL_A = 6;
  localparam int CFG_UPPER_SEL_B = 2;
  localparam logic [3:0] ADDR_PHASE_CYCLES = 4'h1;
  localparam logic [3:0] CMD_CYCLES_8 = 4'h5;
  localparam logic [3:0] CMD_CYCLES_16 = 4'h2;
  localparam logic [3:0] ZWS_CYCLES_8 = 4'h3;
  localparam logic [3:0] ZWS_CYCLES_16 = 4'h2;
  typedef enum logic [1:0] {
    CYC_MEM_RD,
    CYC_MEM_WR,
    CYC_IO_RD,
    CYC_IO_WR
  } isab_cycle_type;
endpackage : isab_pkg

// *** rtl/isab_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination is sys_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module isab_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // data
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RESET_VALUE;
      dout <= RESET_VALUE;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : isab_sync
`default_nettype wire

// *** verif/isab_bus_if_asserts.sv ***
// Purpose: port-level checks of the expansion bus engine
// Assumes: strobes active low, one request in flight
// Notes: bound to every engine instance
`timescale 1ns/1ps
`default_nettype none
module isab_bus_if_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // request side
  input wire logic clockChipMode,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  // bus pins
  input wire logic buffered_addr_latch,
  input wire logic pin_low_mem_write_n_clock_chip_select_n_n,
  input wire logic pin_low_mem_read_n_clock_chip_addr_latch,
  input wire logic byteHighEnableOe,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic dma_addr_enable,
  input wire logic dma_final_count,
  input wire logic extMasterOwns
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence strobeLow;
    !(mem_read_n && mem_write_n && io_read_n && io_write_n);
  endsequence
  sequence latchRise;
    $rose(buffered_addr_latch) && !dma_addr_enable;
  endsequence
  mem_excl_a: assert property (mem_read_n || mem_write_n) else $error("both memory strobes low");
  io_mem_excl_a: assert property (!(io_read_n && io_write_n) |-> (mem_read_n && mem_write_n))
    else $error("io and memory strobes together");
  low_write_a: assert property ((!clockChipMode && !pin_low_mem_write_n_clock_chip_select_n_n) |-> !mem_write_n)
    else $error("low write strobe without memory write");
  low_read_a: assert property ((!clockChipMode && !pin_low_mem_read_n_clock_chip_addr_latch) |-> !mem_read_n)
    else $error("low read strobe without memory read");
  ext_refuse_a: assert property (extMasterOwns |-> !reqReady) else $error("request taken under ext master");
  bhe_input_a: assert property (extMasterOwns |-> !byteHighEnableOe) else $error("byte high driven");
  rsp_pulse_a: assert property (rspValid |=> !rspValid) else $error("response longer than one cycle");
  rsp_bound_a: assert property ((reqValid && reqReady) |-> ##[4:80] rspValid) else $error("no response");
  latch_order_a: assert property (latchRise |-> ##[1:4] strobeLow) else $error("no strobe after latch");
  final_count_a: assert property (dma_final_count |-> dma_addr_enable) else $error("final count outside dma");
endmodule : isab_bus_if_asserts
bind isab_bus_if isab_bus_if_asserts isab_bus_if_asserts_inst (.*);
`default_nettype wire

// *** verif/isab_bus_if_tb.sv ***
// Purpose: self-checking bench of the expansion bus engine
// Assumes: one request at a time, strap caught once after reset release
// Notes: pin activity gathered in sticky flags per cycle
`timescale 1ns/1ps
`default_nettype none
module isab_bus_if_tb;
  import isab_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, masterModeStrap = 1'b0, clockChipMode = 1'b0, reqValid = 1'b0;
  logic reqWide = 1'b0, dmaStart = 1'b0, dmaWide = 1'b0, dmaLast = 1'b0, pciAddrBit0 = 1'b0, wide = 1'b0;
  logic busMasterPin_n = 1'b1, no_wait_request_n = 1'b1;
  logic [2:0] dmaChannel = 3'h1;
  isab_cycle_type reqType = CYC_IO_RD;
  logic [23:0] reqAddr = 24'h000000;
  logic [15:0] reqWdata = 16'h0000, rdData = 16'h0000, sharedAddrDataIn, sharedAddrDataOut, panelAddr, rspRdata;
  logic [15:0] wseen, pseen;
  logic [7:0] dma_request = 8'h00, dma_acknowledge_n;
  logic [3:0] waitCycles = 4'h0, upperAddr, upperAddrOe, generalIoOut, generalIoSeen;
  logic reqReady, rspValid, sharedAddrDataOe, addr_latch_out, addr_xcvr_enable_n, pin_low_mem_write_n_clock_chip_select_n_n;
  logic pin_low_mem_read_n_clock_chip_addr_latch, byteHighEnableOut_n, byteHighEnableOe, buffered_addr_latch, channelReadyIn;
  logic channelReadyOe, io_wide_select_n, mem_wide_select_n, mem_read_n, mem_write_n, io_read_n, io_write_n;
  logic dma_addr_enable, dma_final_count, kbd_rom_select_n, extMasterOwns;
  logic [10:0] seen;
  int fail_count = 0, n_tests = 0, lat;
  always #4 sys_clk = ~sys_clk;
  // gpio and slave-side inputs tied: no rule of this block reaches them
  isab_bus_if isab_bus_if_inst (.upperPinCfg(8'h44), .romRange(3'h1), .slaveBusy(1'b0), .generalIoIn(4'h0),
    .byteHighEnableIn_n(1'b1), .*);
  isab_slave_model isab_slave_model_inst (.*);
  always @(posedge sys_clk) begin
    seen <= seen | {byteHighEnableOe & ~byteHighEnableOut_n, dma_addr_enable, dma_final_count,
      ~dma_acknowledge_n[1], ~kbd_rom_select_n, clockChipMode ? pin_low_mem_read_n_clock_chip_addr_latch : ~pin_low_mem_read_n_clock_chip_addr_latch,
      ~pin_low_mem_write_n_clock_chip_select_n_n, ~io_write_n, ~io_read_n, ~mem_write_n, ~mem_read_n};
    if (!io_write_n || !mem_write_n) wseen <= sharedAddrDataOut;
    if (buffered_addr_latch) pseen <= panelAddr;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input logic m);
    arst_n <= 1'b0;
    masterModeStrap <= m;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset
  task automatic run_cycle(input isab_cycle_type t, input logic [23:0] a, input logic [15:0] d, input logic w);
    @(negedge sys_clk) seen = '0;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqType <= t;
    reqAddr <= a;
    reqWdata <= d;
    reqWide <= w;
    wide <= w;
    lat = 0;
    do @(posedge sys_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    while (rspValid !== 1'b1 && lat < 100) begin
      @(posedge sys_clk);
      lat++;
    end
    chk("response", 16'h0001, {15'h0000, rspValid});
  endtask : run_cycle
  task automatic t_io_decode();
    logic [15:0] ports [6] = '{16'h0071, 16'h0060, 16'h0062, 16'h0064, 16'h0066, 16'h0070};
    logic [3:0] exps [6] = '{4'h7, 4'h9, 4'h9, 4'h9, 4'h9, 4'h1};
    clockChipMode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      run_cycle(CYC_IO_WR, {8'h00, ports[i]}, 16'h12A5, 1'b0);
      chk("io selects", {12'h000, exps[i]}, {12'h000, seen[6:3]});
      chk("io wdata", 16'h00A5, {8'h00, wseen[7:0]});
    end
    rdData <= 16'h5AC3;
    run_cycle(CYC_IO_RD, 24'h000071, 16'h0000, 1'b0);
    chk("narrow read", 16'h00C3, rspRdata);
    run_cycle(CYC_IO_RD, 24'h000300, 16'h0000, 1'b1);
    chk("wide read", 16'h5AC3, rspRdata);
  endtask : t_io_decode
  task automatic t_mem_limits();
    isab_cycle_type kinds [4] = '{CYC_MEM_WR, CYC_MEM_WR, CYC_MEM_RD, CYC_MEM_RD};
    logic [23:0] addrs [4] = '{24'h0FFFFF, 24'h100000, 24'h0FFFFF, 24'h100000};
    logic [6:0] exps [4] = '{7'h52, 7'h02, 7'h61, 7'h01};
    clockChipMode <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      run_cycle(kinds[i], addrs[i], 16'h0011, 1'b0);
      chk("mem strobes", {9'h000, exps[i]}, {9'h000, seen[6:0]});
    end
  endtask : t_mem_limits
  task automatic t_timing();
    int base, fast;
    run_cycle(CYC_MEM_RD, 24'h000010, 16'h0000, 1'b0);
    base = lat;
    no_wait_request_n <= 1'b0;
    run_cycle(CYC_MEM_RD, 24'h000010, 16'h0000, 1'b0);
    fast = lat;
    no_wait_request_n <= 1'b1;
    chk("zero wait gain", 16'h0002, 16'(base - fast));
    waitCycles <= 4'h8;
    run_cycle(CYC_MEM_RD, 24'h000010, 16'h0000, 1'b0);
    waitCycles <= 4'h0;
    chk("stretched", 16'h0001, {15'h0000, lat > base + 2});
  endtask : t_timing
  task automatic t_dma(input logic w, input logic b);
    @(negedge sys_clk) seen = '0;
    @(posedge sys_clk);
    dma_request <= 8'h02;
    dmaWide <= w;
    pciAddrBit0 <= b;
    dmaLast <= 1'b1;
    repeat (3) @(posedge sys_clk);
    dmaStart <= 1'b1;
    @(posedge sys_clk);
    dmaStart <= 1'b0;
    for (int k = 0; k < 80 && !(seen[9] && !dma_addr_enable); k++) begin
      @(posedge sys_clk);
      if (!dma_acknowledge_n[1]) dma_request <= 8'h00;
    end
    chk("dma pins", {12'h000, w | b, 3'h7}, {12'h000, seen[10:7]});
  endtask : t_dma
  task automatic t_master();
    do_reset(1'b1);
    chk("xcvr enable", 16'h0000, {15'h0000, addr_xcvr_enable_n});
    run_cycle(CYC_MEM_WR, 24'h001234, 16'hBEEF, 1'b1);
    chk("panel addr", 16'h1234, pseen);
    chk("wide wdata", 16'hBEEF, wseen);
    busMasterPin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("ext owner", 16'h000C, {12'h000, addr_latch_out, extMasterOwns, reqReady, byteHighEnableOe});
    busMasterPin_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("ext released", 16'h0001, {13'h0000, addr_latch_out, extMasterOwns, reqReady});
  endtask : t_master
  initial begin
    do_reset(1'b0);
    chk("idle pins", 16'h03F9, {6'h00, mem_read_n, mem_write_n, io_read_n, io_write_n, kbd_rom_select_n,
      pin_low_mem_write_n_clock_chip_select_n_n, pin_low_mem_read_n_clock_chip_addr_latch, sharedAddrDataOe, dma_addr_enable, byteHighEnableOe});
    chk("upper pins", 16'h000F, {12'h000, upperAddrOe});
    t_io_decode();
    t_mem_limits();
    t_timing();
    t_dma(1'b0, 1'b0);
    t_dma(1'b0, 1'b1);
    t_dma(1'b1, 1'b0);
    t_master();
    tally_and_finish();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : isab_bus_if_tb
`default_nettype wire

// *** verif/isab_slave_model.sv ***
// Purpose: behavioural slave on the far side of the bus
// Assumes: ready answered from strobe length
// Notes: released data lines float up through the pull-ups
`timescale 1ns/1ps
`default_nettype none
module isab_slave_model (
  // clock and strobes
  input wire logic sys_clk,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic io_read_n,
  input wire logic io_write_n,
  // bench controls
  input wire logic [3:0] waitCycles,
  input wire logic wide,
  input wire logic [15:0] rdData,
  // pins toward the engine
  output logic [15:0] sharedAddrDataIn,
  output logic channelReadyIn,
  output logic io_wide_select_n,
  output logic mem_wide_select_n
);
  logic [3:0] held = 4'h0;
  wire logic active = !(mem_read_n && mem_write_n && io_read_n && io_write_n);
  always @(posedge sys_clk) held <= !active ? 4'h0 : (held == 4'hF) ? held : held + 4'h1;
  assign channelReadyIn = !active || (held >= waitCycles);
  assign sharedAddrDataIn = (!mem_read_n || !io_read_n) ? rdData : 16'hFFFF;
  assign io_wide_select_n = !wide;
  assign mem_wide_select_n = !wide;
endmodule : isab_slave_model
`default_nettype wire
